/* File: rtl/trace_cfg.svh */
// Behaviour
// R1: Decide storage and break from mode, matches
// R2: Begin-trigger stores after trigger until 64 words
// R3: End-trigger stores until trigger, oldest overwritten
// R4: Arming needs enable and arm both set
// R5: Hardware clears arm on end trigger, begin full
// R6: Setting arm clears A, B, C flags
// R7: Contents: change-of-flow, event data, or detail
// R8: A-only: A match sets A, triggers
// R9: A-or-B: either match sets flag, triggers
// R10: A-then-B: B counts after A; then trigger
// R11: Event-only B: B triggers, begin, selects ignored
// R12: A-then-event-B: each B after A triggers
// R13: Detail capture reduces event-only modes, honours selects
// R14: A-and-B: address and data same cycle trigger
// R15: A-and-not-B: address match, data mismatch triggers
// R16: Tagged full modes use only comparator A
// R17: Forced odd-address word data compare never matches; here it still matches when misalign_ok is set
// R18: Inside range sets both flags, triggers
// R19: Outside range sets matching flag, triggers
// R20: Ranges word-accurate tagged, aligned address forced
// R21: Tagged triggering ignores read/write enables
// R22: Four capture modes; normal uses A and B
// R23: Tagged matches come from opcode tracking
// R24: Armed trace read returns invalid, no advance
// R25: Four-bit mode code, unused codes mean A-only
`ifndef TRACE_CFG_SVH
`define TRACE_CFG_SVH

// Register byte offsets
`define OFS_CTRL_FIRST 8'h00
`define OFS_STATUS_CTRL 8'h04
`define OFS_RW_CMP 8'h08
`define OFS_COUNT 8'h0C
`define OFS_TRACE 8'h10
`define OFS_CMP_A 8'h14
`define OFS_CMP_B 8'h18

// First control register fields
`define CTRL_EN 7
`define CTRL_ARM 6
`define CTRL_TTS 5
`define CTRL_BEGIN 4
`define CTRL_BRK 3
`define CTRL_CAP_HI 1
`define CTRL_CAP_LO 0

// Status and control register fields
`define STAT_FLAG_A 7
`define STAT_FLAG_B 6
`define STAT_FLAG_C 5
`define STAT_TRG_HI 3
`define STAT_TRG_LO 0

// Read/write compare register fields
`define RWC_EN_A 3
`define RWC_A 2
`define RWC_EN_B 1
`define RWC_B 0

// Misc values
`define TRACE_INVALID 16'h0000
`define TRG_MODE_MAX 4'h8
`define TRACE_DEPTH 64

`endif

/* File: rtl/trace_pkg.sv */
package trace_pkg;

	// Trigger modes in field code order
	typedef enum logic [3:0] {
		TM_A_ONLY,
		TM_A_OR_B,
		TM_A_THEN_B,
		TM_EV_B,
		TM_A_THEN_EV_B,
		TM_A_AND_B,
		TM_A_AND_NOT_B,
		TM_INSIDE,
		TM_OUTSIDE,
		TM_B_ONLY
	} trig_mode_t;

	// Capture modes in field code order
	typedef enum logic [1:0] {
		CM_NORMAL,
		CM_LOOP1,
		CM_DETAIL,
		CM_PROFILE
	} cap_mode_t;

endpackage

/* File: rtl/trace_store_controller.sv */
// The address map and the APB slave port are this design's own decisions.
`include "trace_cfg.svh"

module trace_store_controller import trace_pkg::*; #(
	parameter int DEPTH = `TRACE_DEPTH,
	parameter int ADDR_W = 8
) (
	input wire logic mclk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core bus cycle
	input wire logic bus_valid,
	input wire logic [15:0] bus_addr,
	input wire logic [15:0] bus_data,
	input wire logic bus_read,
	input wire logic bus_word,
	input wire logic bus_pfetch,
	input wire logic bus_free,
	input wire logic misalign_ok,
	// Change-of-flow item
	input wire logic cof_valid,
	input wire logic [15:0] cof_addr,
	// Opcode tracking: instruction about to execute
	input wire logic tag_valid,
	input wire logic [15:0] tag_addr,
	// Comparator C hit
	input wire logic comp_c_hit,
	// Results
	output logic break_req,
	output logic armed
);

	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = PTR_W + 1;
	localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
	localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(DEPTH - 1);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// Clear bit 0 to get the word-aligned address
	function automatic logic [15:0] word_align(input logic [15:0] a);
		word_align = {a[15:1], 1'b0};
	endfunction

	// Read/write qualification of a forced compare
	function automatic logic rw_ok(input logic en, input logic want_rd, input logic rd);
		rw_ok = !en || (want_rd == rd);
	endfunction

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------

	logic dbg_en; // Module enable
	logic tts; // Tagged trigger select
	logic begin_sel; // Begin-trigger select
	logic brk_en; // Break request enable
	logic [1:0] cap_field; // Capture mode code
	logic [3:0] trg_field; // Trigger mode code
	logic flag_a; // Comparator A flag
	logic flag_b; // Comparator B flag
	logic flag_c; // Comparator C flag
	logic rwen_a; // Read/write compare enable A
	logic rw_a; // Read/write select A
	logic rwen_b; // Read/write compare enable B
	logic rw_b; // Read/write select B
	logic [15:0] cmp_a; // Comparator A value
	logic [15:0] cmp_b; // Comparator B value

	// Capture state
	logic triggered; // Trigger seen since arming
	logic seen_a; // A matched in sequence modes
	logic [PTR_W-1:0] wr_ptr; // Next write slot
	logic [CNT_W-1:0] count; // Valid words, saturating
	logic [PTR_W-1:0] rd_ofs; // Readout offset from oldest
	logic pend_v; // Detail data word waiting
	logic [15:0] pend_data; // Detail data word
	logic [15:0] mem [0:DEPTH-1]; // Circular trace buffer

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------

	wire setup_ph = psel && !penable;
	wire access_ph = psel && penable;
	wire hit_ctrl = paddr == ADDR_W'(`OFS_CTRL_FIRST);
	wire hit_stat = paddr == ADDR_W'(`OFS_STATUS_CTRL);
	wire hit_rwc = paddr == ADDR_W'(`OFS_RW_CMP);
	wire hit_cnt = paddr == ADDR_W'(`OFS_COUNT);
	wire hit_trc = paddr == ADDR_W'(`OFS_TRACE);
	wire hit_ca = paddr == ADDR_W'(`OFS_CMP_A);
	wire hit_cb = paddr == ADDR_W'(`OFS_CMP_B);
	wire mapped = hit_ctrl || hit_stat || hit_rwc || hit_cnt || hit_trc || hit_ca || hit_cb;
	wire wr_acc = access_ph && pwrite;
	wire wr_ctrl = wr_acc && hit_ctrl;
	wire wr_stat = wr_acc && hit_stat;
	wire wr_rwc = wr_acc && hit_rwc;
	// Arming needs both enable and arm written high
	wire arm_set = wr_ctrl && pwdata[`CTRL_EN] && pwdata[`CTRL_ARM]; // [R4]
	wire trc_rd = access_ph && !pwrite && hit_trc;

	// Zero wait states; unmapped addresses answer an error
	assign pready = access_ph;
	assign pslverr = access_ph && !mapped;

	// ------------------------------------------------------------
	// Mode resolution
	// ------------------------------------------------------------

	// Unused codes fall back to A-only
	wire [3:0] trg_safe = (trg_field > `TRG_MODE_MAX) ? 4'h0 : trg_field; // [R25]
	wire trig_mode_t raw_mode = trig_mode_t'(trg_safe);
	wire cap_mode_t cap = cap_mode_t'(cap_field);
	wire detail = cap == CM_DETAIL; // [R22]
	wire profile = cap == CM_PROFILE; // [R22]
	// Detail capture reduces event-only modes
	wire trig_mode_t mode = !detail ? raw_mode :
		(raw_mode == TM_EV_B) ? TM_B_ONLY :
		(raw_mode == TM_A_THEN_EV_B) ? TM_A_THEN_B : raw_mode; // [R13]
	wire event_only = (mode == TM_EV_B) || (mode == TM_A_THEN_EV_B);
	// Event-only modes are always begin-trigger
	wire begin_eff = event_only || begin_sel; // [R11] [R12]
	wire full_mode = (mode == TM_A_AND_B) || (mode == TM_A_AND_NOT_B);
	wire active = armed && !profile;

	// ------------------------------------------------------------
	// Comparators
	// ------------------------------------------------------------

	// Tagged compares take the opcode-tracking address
	wire tag_a = tts && (mode != TM_EV_B); // [R11] [R23]
	wire tag_b = tts && !event_only; // [R12] [R23]
	// Read/write enables drop out when tagged
	wire rwa_ok = tts || rw_ok(rwen_a, rw_a, bus_read); // [R21]
	wire rwb_ok = tts || rw_ok(rwen_b, rw_b, bus_read); // [R21]
	wire a_valid = tag_a ? tag_valid : (bus_valid && rwa_ok); // [R23]
	wire [15:0] a_addr = tag_a ? word_align(tag_addr) : bus_addr;
	wire b_valid = tag_b ? tag_valid : (bus_valid && rwb_ok);
	wire [15:0] b_addr = tag_b ? word_align(tag_addr) : bus_addr;
	wire ma = a_valid && (a_addr == cmp_a);
	wire mb = b_valid && (b_addr == cmp_b);
	// Misaligned word data never matches unless memory copes
	wire data_bad = bus_word && bus_addr[0] && !misalign_ok; // [R17]
	wire db = bus_valid && rwa_ok && (bus_data == cmp_b) && !data_bad; // [R14] [R17]
	wire fa = bus_valid && rwa_ok && (bus_addr == cmp_a);
	// Range address: word-aligned tagged or aligned word access
	wire r_valid = tts ? tag_valid : (bus_valid && rwa_ok); // [R20]
	wire [15:0] r_addr = (tts || bus_word) ? word_align(tts ? tag_addr : bus_addr) : bus_addr; // [R20]
	wire ge_a = r_addr >= cmp_a;
	wire le_b = r_addr <= cmp_b;

	// ------------------------------------------------------------
	// Trigger decision per mode
	// ------------------------------------------------------------

	logic set_a; // Raise A flag
	logic set_b; // Raise B flag
	logic trig; // Trigger this cycle

	always_comb begin // [R1]
		set_a = 1'b0;
		set_b = 1'b0;
		trig = 1'b0;
		case (mode)
			TM_A_ONLY: begin // [R8]
				set_a = ma;
				trig = ma;
			end
			TM_A_OR_B: begin // [R9]
				set_a = ma;
				set_b = mb;
				trig = ma || mb;
			end
			TM_B_ONLY, TM_EV_B: begin // [R11] [R13]
				set_b = mb;
				trig = mb;
			end
			TM_A_THEN_B, TM_A_THEN_EV_B: begin // [R10] [R12]
				set_a = ma;
				set_b = mb && seen_a;
				trig = mb && seen_a;
			end
			TM_A_AND_B: begin // [R14] [R16]
				if (tts) begin
					set_a = ma;
					trig = ma;
				end else begin
					set_a = fa && db;
					set_b = fa && db;
					trig = fa && db;
				end
			end
			TM_A_AND_NOT_B: begin // [R15] [R16]
				if (tts) begin
					set_a = ma;
					trig = ma;
				end else begin
					set_a = fa && !db;
					set_b = fa && !db;
					trig = fa && !db;
				end
			end
			TM_INSIDE: begin // [R18]
				set_a = r_valid && ge_a && le_b;
				set_b = r_valid && ge_a && le_b;
				trig = r_valid && ge_a && le_b;
			end
			TM_OUTSIDE: begin // [R19]
				set_a = r_valid && !ge_a;
				set_b = r_valid && !le_b;
				trig = r_valid && (!ge_a || !le_b);
			end
			default: begin
				set_a = ma;
				trig = ma;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Storage decision
	// ------------------------------------------------------------

	// What one capture cycle offers to the buffer
	wire detail_item = bus_valid && !bus_pfetch && !bus_free;
	wire item_v = event_only ? trig : (detail ? detail_item : cof_valid); // [R7]
	wire [15:0] item_word = event_only ? bus_data : (detail ? bus_addr : cof_addr); // [R7]
	wire trig_act = active && trig;
	// Begin: from trigger, trigger item kept; end: until trigger, trigger item dropped
	wire store_now = active && item_v && !pend_v &&
		(begin_eff ? (triggered || trig) : !trig); // [R2] [R3]
	wire wr_en = (active && pend_v) || store_now;
	wire [15:0] wr_word = pend_v ? pend_data : item_word;
	wire full_hit = begin_eff && wr_en && (count == LAST_CNT); // [R2]
	wire end_hit = !begin_eff && trig_act; // [R3]
	wire hw_disarm = active && (full_hit || end_hit); // [R5]
	wire [CNT_W-1:0] next_count = (count == FULL_CNT) ? count : count + 1'b1; // [R3]
	wire [PTR_W-1:0] rd_base = wr_ptr - count[PTR_W-1:0];
	wire [PTR_W-1:0] rd_idx = rd_base + rd_ofs;

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------

	// Control fields written by software
	always_ff @(posedge mclk) begin
		if (rst) begin
			dbg_en <= 1'b0;
			tts <= 1'b0;
			begin_sel <= 1'b0;
			brk_en <= 1'b0;
			cap_field <= 2'h0;
			trg_field <= 4'h0;
			rwen_a <= 1'b0;
			rw_a <= 1'b0;
			rwen_b <= 1'b0;
			rw_b <= 1'b0;
			cmp_a <= 16'h0000;
			cmp_b <= 16'h0000;
		end else begin
			if (wr_ctrl) begin
				dbg_en <= pwdata[`CTRL_EN];
				tts <= pwdata[`CTRL_TTS];
				begin_sel <= pwdata[`CTRL_BEGIN];
				brk_en <= pwdata[`CTRL_BRK];
				cap_field <= pwdata[`CTRL_CAP_HI:`CTRL_CAP_LO];
			end
			if (wr_stat) begin
				trg_field <= pwdata[`STAT_TRG_HI:`STAT_TRG_LO];
			end
			if (wr_rwc) begin
				rwen_a <= pwdata[`RWC_EN_A];
				rw_a <= pwdata[`RWC_A];
				rwen_b <= pwdata[`RWC_EN_B];
				rw_b <= pwdata[`RWC_B];
			end
			if (wr_acc && hit_ca) begin
				cmp_a <= pwdata[15:0];
			end
			if (wr_acc && hit_cb) begin
				cmp_b <= pwdata[15:0];
			end
		end
	end

	// Arm bit: software sets/clears, hardware clears
	always_ff @(posedge mclk) begin
		if (rst) begin
			armed <= 1'b0;
		end else if (wr_ctrl) begin
			armed <= arm_set; // [R4]
		end else if (hw_disarm) begin
			armed <= 1'b0; // [R5]
		end
	end

	// Flags: arming clears, a match in the same cycle wins
	always_ff @(posedge mclk) begin
		if (rst) begin
			flag_a <= 1'b0;
			flag_b <= 1'b0;
			flag_c <= 1'b0;
		end else begin
			flag_a <= (flag_a && !arm_set) || (active && set_a); // [R6]
			flag_b <= (flag_b && !arm_set) || (active && set_b); // [R6]
			flag_c <= (flag_c && !arm_set) || (active && comp_c_hit); // [R6]
		end
	end

	// Sequence state for trigger modes
	always_ff @(posedge mclk) begin
		if (rst || arm_set) begin
			triggered <= 1'b0;
			seen_a <= 1'b0;
		end else begin
			if (trig_act) begin
				triggered <= 1'b1;
			end
			if (active && set_a) begin
				seen_a <= 1'b1; // [R10] [R12]
			end
		end
	end

	// ------------------------------------------------------------
	// Trace buffer
	// ------------------------------------------------------------

	// Pointer and count; arming starts a fresh capture
	always_ff @(posedge mclk) begin
		if (rst || arm_set) begin
			wr_ptr <= '0;
			count <= '0;
			pend_v <= 1'b0;
			pend_data <= 16'h0000;
		end else begin
			if (wr_en) begin
				wr_ptr <= wr_ptr + 1'b1; // [R3]
				count <= next_count;
			end
			// Detail capture: data word follows its address
			pend_v <= store_now && detail; // [R7]
			if (store_now && detail) begin
				pend_data <= bus_data;
			end
		end
	end

	// Buffer storage, no reset needed
	always_ff @(posedge mclk) begin
		if (wr_en) begin
			mem[wr_ptr] <= wr_word;
		end
	end

	// Readout walks from the oldest word while disarmed
	always_ff @(posedge mclk) begin
		if (rst || arm_set) begin
			rd_ofs <= '0;
		end else if (trc_rd && !armed) begin
			rd_ofs <= rd_ofs + 1'b1; // [R24]
		end
	end

	// ------------------------------------------------------------
	// Break request
	// ------------------------------------------------------------

	// Pulse on end trigger or begin-mode buffer full
	always_ff @(posedge mclk) begin
		if (rst) begin
			break_req <= 1'b0;
		end else begin
			break_req <= brk_en && hw_disarm && !wr_ctrl; // [R1]
		end
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------

	// Read mux, captured in the setup phase
	wire [31:0] rd_ctrl = {24'h0, dbg_en, armed, tts, begin_sel, brk_en, 1'b0, cap_field};
	wire [31:0] rd_stat = {24'h0, flag_a, flag_b, flag_c, 1'b0, trg_field};
	wire [31:0] rd_rwc = {28'h0, rwen_a, rw_a, rwen_b, rw_b};
	wire [15:0] trc_word = armed ? `TRACE_INVALID : mem[rd_idx]; // [R24]
	wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
		hit_stat ? rd_stat :
		hit_rwc ? rd_rwc :
		hit_cnt ? {{(32-CNT_W){1'b0}}, count} :
		hit_trc ? {16'h0000, trc_word} :
		hit_ca ? {16'h0000, cmp_a} :
		hit_cb ? {16'h0000, cmp_b} : 32'h0000_0000;

	// Read data register
	always_ff @(posedge mclk) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (setup_ph && !pwrite) begin
			prdata <= rd_mux;
		end
	end

endmodule

/* File: bench/trace_store_controller_properties.sv */
`include "trace_cfg.svh"

module trace_checker import trace_pkg::*; #(
	parameter int ADDR_W = 8
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic bus_valid,
	input wire logic [15:0] bus_addr,
	input wire logic bus_word,
	input wire logic break_req,
	input wire logic armed
);
	// ----------------------------------------
	// Register shadows
	// ----------------------------------------
	logic [7:0] ctrl; // Control byte as written
	logic [3:0] mode; // Trigger mode field
	logic [15:0] cmp_a; // Comparator A value
	logic [15:0] cmp_b; // Comparator B value
	wire wr = psel && penable && pwrite; // Write access
	wire wr_ctrl = wr && paddr == `OFS_CTRL_FIRST; // Control write
	wire hit = armed && bus_valid && !bus_word && !ctrl[`CTRL_TTS] && !ctrl[`CTRL_BEGIN]
		&& ctrl[1:0] == 2'h0 && !wr_ctrl; // Forced end-trigger byte cycle

	// Shadows follow completed writes
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl <= 8'h00;
			mode <= 4'h0;
			cmp_a <= 16'h0000;
			cmp_b <= 16'h0000;
		end else if (wr) begin
			if (paddr == `OFS_CTRL_FIRST) ctrl <= pwdata[7:0];
			if (paddr == `OFS_STATUS_CTRL) mode <= pwdata[3:0];
			if (paddr == `OFS_CMP_A) cmp_a <= pwdata[15:0];
			if (paddr == `OFS_CMP_B) cmp_b <= pwdata[15:0];
		end
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	property p_arm_needs_both;
		$rose(armed) |-> $past(wr_ctrl) && $past(pwdata[`CTRL_EN]) && $past(pwdata[`CTRL_ARM]);
	endproperty
	a_arm_needs_both: assert property (p_arm_needs_both) else $error("arming without both bits");

	property p_other_write_disarms;
		wr_ctrl && !(pwdata[`CTRL_EN] && pwdata[`CTRL_ARM]) |=> !armed;
	endproperty
	a_other_write_disarms: assert property (p_other_write_disarms) else $error("still armed");

	property p_a_only;
		hit && mode == TM_A_ONLY && bus_addr == cmp_a |=> !armed;
	endproperty
	a_a_only: assert property (p_a_only) else $error("no end trigger on A match");

	property p_inside;
		hit && mode == TM_INSIDE && bus_addr >= cmp_a && bus_addr <= cmp_b |=> !armed;
	endproperty
	a_inside: assert property (p_inside) else $error("no inside range trigger");

	property p_inside_miss;
		hit && mode == TM_INSIDE && bus_addr > cmp_b |=> armed;
	endproperty
	a_inside_miss: assert property (p_inside_miss) else $error("trigger outside range");

	property p_outside;
		hit && mode == TM_OUTSIDE && (bus_addr < cmp_a || bus_addr > cmp_b) |=> !armed;
	endproperty
	a_outside: assert property (p_outside) else $error("no outside range trigger");

	property p_break_pulse;
		$rose(break_req) |=> !break_req;
	endproperty
	a_break_pulse: assert property (p_break_pulse) else $error("break longer than one cycle");

	property p_break_after_disarm;
		break_req |-> $past(armed) && !armed && ctrl[`CTRL_BRK];
	endproperty
	a_break_after_disarm: assert property (p_break_after_disarm) else $error("break out of place");

	property p_armed_read;
		psel && penable && !pwrite && paddr == `OFS_TRACE && $past(armed) |-> prdata[15:0] == `TRACE_INVALID;
	endproperty
	a_armed_read: assert property (p_armed_read) else $error("armed trace read valid");
endmodule

/* File: bench/core_bus_model.sv */
module core_bus_model (
	input wire logic mclk,
	output logic bus_valid,
	output logic [15:0] bus_addr,
	output logic [15:0] bus_data,
	output logic bus_read,
	output logic bus_word,
	output logic bus_pfetch,
	output logic bus_free,
	output logic misalign_ok,
	output logic cof_valid,
	output logic [15:0] cof_addr,
	output logic tag_valid,
	output logic [15:0] tag_addr,
	output logic comp_c_hit
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// Idle lines
	// ----------------------------------------
	initial begin
		{bus_valid, bus_read, bus_word, bus_pfetch, bus_free} = 5'h02;
		{misalign_ok, cof_valid, tag_valid, comp_c_hit} = 4'h0;
		{bus_addr, bus_data, cof_addr, tag_addr} = 64'h0;
	end

	// One opcode-tracking tag, address then shows inverse
	task automatic tag(input logic [15:0] a);
		@(posedge mclk);
		tag_valid <= 1'b1;
		tag_addr <= a;
		@(posedge mclk);
		tag_valid <= 1'b0;
		tag_addr <= ~a;
	endtask

	// One bus cycle, address and data then show inverse
	task automatic bus(input logic [15:0] a, input logic [15:0] d, input logic w, input logic mis);
		@(posedge mclk);
		bus_valid <= 1'b1;
		bus_addr <= a;
		bus_data <= d;
		bus_word <= w;
		misalign_ok <= mis;
		@(posedge mclk);
		bus_valid <= 1'b0;
		bus_addr <= ~a;
		bus_data <= ~d;
	endtask

	// One change-of-flow item
	task automatic cof(input logic [15:0] a);
		@(posedge mclk);
		cof_valid <= 1'b1;
		cof_addr <= a;
		@(posedge mclk);
		cof_valid <= 1'b0;
		cof_addr <= ~a;
	endtask
endmodule

/* File: bench/debug_trace_trigger_control_tb_top.sv */
`include "trace_cfg.svh"

module debug_trace_trigger_control_tb_top import trace_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int DEPTH = 8; // Shortened buffer
	logic mclk, rst, psel, penable, pwrite, pready, pslverr, break_req, armed;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic bus_valid, bus_read, bus_word, bus_pfetch, bus_free, misalign_ok, cof_valid, tag_valid, comp_c_hit;
	logic [15:0] bus_addr, bus_data, cof_addr, tag_addr;
	int mismatches, tests_run, breaks;

	trace_store_controller #(.DEPTH(DEPTH), .ADDR_W(8)) u_trace_store_controller (.mclk(mclk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bus_valid(bus_valid), .bus_addr(bus_addr), .bus_data(bus_data),
		.bus_read(bus_read), .bus_word(bus_word), .bus_pfetch(bus_pfetch), .bus_free(bus_free),
		.misalign_ok(misalign_ok), .cof_valid(cof_valid), .cof_addr(cof_addr), .tag_valid(tag_valid),
		.tag_addr(tag_addr), .comp_c_hit(comp_c_hit), .break_req(break_req), .armed(armed));
	core_bus_model u_core_bus_model (.mclk(mclk), .bus_valid(bus_valid), .bus_addr(bus_addr),
		.bus_data(bus_data), .bus_read(bus_read), .bus_word(bus_word), .bus_pfetch(bus_pfetch),
		.bus_free(bus_free), .misalign_ok(misalign_ok), .cof_valid(cof_valid), .cof_addr(cof_addr),
		.tag_valid(tag_valid), .tag_addr(tag_addr), .comp_c_hit(comp_c_hit));

	// ----------------------------------------
	// Clock and break monitor
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (break_req === 1'b1) breaks++;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic complete_run();
		if (mismatches == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		int i;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge mclk);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			mismatches++;
			complete_run();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk(n, exp, q & m);
	endtask
	task automatic arm(input logic [3:0] md, input logic [31:0] c);
		wr(`OFS_STATUS_CTRL, {28'h0, md});
		wr(`OFS_CTRL_FIRST, c);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic s_reset();
		logic [31:0] q;
		logic e;
		rd("ctrl", `OFS_CTRL_FIRST, 32'hFFFFFFFF, 32'h0);
		apb(1'b0, 8'h1C, 32'h0, q, e);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
	endtask
	task automatic s_end_trigger();
		wr(`OFS_CMP_A, 32'h1234);
		arm(TM_A_ONLY, 32'hC8);
		for (int k = 1; k <= DEPTH + 2; k++) u_core_bus_model.cof(16'h0100 + k[15:0]);
		rd("armed trace", `OFS_TRACE, 32'hFFFF, `TRACE_INVALID);
		u_core_bus_model.bus(16'h1235, 16'h0, 1'b0, 1'b0);
		rd("armed", `OFS_CTRL_FIRST, 32'h40, 32'h40);
		u_core_bus_model.bus(16'h1234, 16'h0, 1'b0, 1'b0);
		rd("disarmed", `OFS_CTRL_FIRST, 32'h40, 32'h0);
		chk("break", 32'h1, breaks);
		rd("flags", `OFS_STATUS_CTRL, 32'hE0, 32'h80);
		rd("count", `OFS_COUNT, 32'hFF, DEPTH);
		rd("oldest", `OFS_TRACE, 32'hFFFF, 32'h0103);
		rd("next", `OFS_TRACE, 32'hFFFF, 32'h0104);
	endtask
	task automatic s_begin();
		wr(`OFS_CTRL_FIRST, 32'h40);
		rd("arm alone", `OFS_CTRL_FIRST, 32'h40, 32'h0);
		wr(`OFS_CTRL_FIRST, 32'hD0);
		rd("flags cleared", `OFS_STATUS_CTRL, 32'hE0, 32'h0);
		u_core_bus_model.cof(16'h0200);
		u_core_bus_model.bus(16'h1234, 16'h0, 1'b0, 1'b0);
		for (int k = 1; k <= DEPTH + 2; k++) u_core_bus_model.cof(16'h0200 + k[15:0]);
		rd("full disarmed", `OFS_CTRL_FIRST, 32'h40, 32'h0);
		rd("count", `OFS_COUNT, 32'hFF, DEPTH);
		rd("first", `OFS_TRACE, 32'hFFFF, 32'h0201);
	endtask
	task automatic s_range();
		wr(`OFS_CMP_B, 32'h2000);
		arm(TM_INSIDE, 32'hC0);
		u_core_bus_model.bus(16'h2001, 16'h0, 1'b0, 1'b0);
		rd("above range", `OFS_CTRL_FIRST, 32'h40, 32'h40);
		u_core_bus_model.bus(16'h2000, 16'h0, 1'b0, 1'b0);
		rd("inside", `OFS_STATUS_CTRL, 32'hE0, 32'hC0);
		arm(TM_OUTSIDE, 32'hC0);
		u_core_bus_model.bus(16'h2001, 16'h0, 1'b0, 1'b0);
		rd("outside", `OFS_CTRL_FIRST, 32'h40, 32'h0);
		rd("outside flag", `OFS_STATUS_CTRL, 32'hE0, 32'h40);
	endtask
	task automatic s_a_then_b();
		arm(TM_A_THEN_B, 32'hC0);
		u_core_bus_model.bus(16'h2000, 16'h0, 1'b0, 1'b0);
		u_core_bus_model.bus(16'h1234, 16'h0, 1'b0, 1'b0);
		rd("after A", `OFS_CTRL_FIRST, 32'h40, 32'h40);
		u_core_bus_model.bus(16'h2000, 16'h0, 1'b0, 1'b0);
		rd("after B", `OFS_STATUS_CTRL, 32'hE0, 32'hC0);
		rd("sequence", `OFS_CTRL_FIRST, 32'h40, 32'h0);
	endtask
	task automatic s_full();
		wr(`OFS_CMP_A, 32'h1235);
		wr(`OFS_CMP_B, 32'h55AA);
		arm(TM_A_AND_NOT_B, 32'hC0);
		u_core_bus_model.bus(16'h1235, 16'h55AA, 1'b1, 1'b1);
		rd("data equal", `OFS_CTRL_FIRST, 32'h40, 32'h40);
		u_core_bus_model.bus(16'h1235, 16'h55AA, 1'b1, 1'b0);
		rd("misaligned", `OFS_STATUS_CTRL, 32'hE0, 32'hC0);
		chk("no break", 32'h1, breaks);
	endtask
	task automatic s_tagged();
		wr(`OFS_CMP_A, 32'h1234);
		arm(TM_A_AND_B, 32'hE0);
		u_core_bus_model.bus(16'h1234, 16'h55AA, 1'b0, 1'b0);
		rd("bus ignored tagged", `OFS_CTRL_FIRST, 32'h40, 32'h40);
		u_core_bus_model.tag(16'h1235);
		rd("tagged A only", `OFS_STATUS_CTRL, 32'hE0, 32'h80);
		rd("tagged disarmed", `OFS_CTRL_FIRST, 32'h40, 32'h0);
		arm(TM_A_OR_B, 32'hC0);
		u_core_bus_model.bus(16'h55AA, 16'h0, 1'b0, 1'b0);
		rd("either B", `OFS_STATUS_CTRL, 32'hE0, 32'h40);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{rst, psel, penable, pwrite} = 4'h8;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		s_reset();
		s_end_trigger();
		s_begin();
		s_range();
		s_a_then_b();
		s_full();
		s_tagged();
		complete_run();
	end
endmodule

bind trace_store_controller trace_checker #(.ADDR_W(ADDR_W)) u_trace_checker (.mclk(mclk), .rst(rst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.bus_valid(bus_valid), .bus_addr(bus_addr), .bus_word(bus_word), .break_req(break_req), .armed(armed));
